// ==== rtl/srs_pkg.sv ====
package srs_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ = 10_000_000;     // Oscillator and bus clock
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int QC_TIMEOUT_MS = 1000;    // Quality check timeout
    localparam int QC_TIMEOUT_CYC = QC_TIMEOUT_MS * CYC_PER_MS;
    localparam int QC_GOOD_CYC = 4096;      // Stable oscillation needed
    localparam int RST_PULSE_MIN = 2;       // Reset pulse, osc periods
    localparam int STARTUP_OSC = 196;       // Reset startup, osc periods
    localparam int WAKE_DLY_CYC = 4;        // Wake to vector fetch
    localparam int CNT_W = 24;              // Shared counter width

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;  // Mode request
    localparam logic [7:0] ADDR_STAT = 8'h04;  // Status and flags
    localparam int CTRL_MODE_LSB = 0;          // Two-bit mode field
    localparam logic [1:0] MODE_STOP = 2'h1;
    localparam logic [1:0] MODE_PSTOP = 2'h2;
    localparam logic [1:0] MODE_WAIT = 2'h3;
    localparam int STAT_POR = 0;    // power_on_flag, write one clears
    localparam int STAT_SELF = 1;   // Running on self clock
    localparam int STAT_WARN = 2;   // supply_low_warning
    localparam int STAT_FULL = 3;   // Full performance regulator
    localparam int STAT_OSC = 4;    // Oscillator enabled

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic ext_rst_n;    // External reset pin
        logic osc_ok;       // Oscillation detected
        logic ext_irq;      // External interrupt pin
        logic supply_low;   // Analog supply below warning level
        logic core_uv;      // Core supply below reset level
    } srs_pins_s;

    typedef enum logic [2:0] {
        ST_RST, ST_QC, ST_RUN, ST_STOP, ST_PSTOP, ST_WAIT, ST_WAKE
    } srs_state_e;

endpackage

// ==== rtl/srs_top.sv ====
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
module srs_top #(
    parameter int TO_CYC = srs_pkg::QC_TIMEOUT_CYC  // Timeout cycles
) (
    input wire logic ref_clk,                   // 10 MHz clock
    input wire logic sys_rst,                   // Power-on reset
    input wire logic hsel,                      // AHB select
    input wire logic [31:0] haddr,              // AHB address
    input wire logic [1:0] htrans,              // AHB transfer type
    input wire logic hwrite,                    // AHB write
    input wire logic [2:0] hsize,               // AHB size, word only
    input wire logic [31:0] hwdata,             // AHB write data
    input wire logic hready,                    // AHB bus ready
    output logic [31:0] hrdata,                 // AHB read data
    output logic hreadyout,                     // AHB slave ready
    output logic hresp,                         // AHB response
    input wire srs_pkg::srs_pins_s pins,        // Asynchronous pins
    input wire logic int_irq,                   // Internal interrupt
    output logic int_rst,                       // Internal reset
    output logic clk_release,                   // System clocks on
    output logic osc_enable,                    // Oscillator enable
    output logic self_clock,                    // Self clock selected
    output logic rst_vec_fetch,                 // Reset vector pulse
    output logic irq_vec_fetch,                 // Irq vector pulse
    output logic full_perf,                     // Regulator mode
    output logic supply_low_warning,            // Gated warning
    output logic core_undervoltage_reset        // Monitor causing reset
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    localparam int PIN_W = $bits(srs_pkg::srs_pins_s);
    localparam logic [PIN_W-1:0] PIN_IDLE = 5'h10;  // Reset pin high
    logic [PIN_W-1:0] s1_r;     // First stage, read by s2_r only
    logic [PIN_W-1:0] s2_r;     // Second stage
    srs_pkg::srs_pins_s pin;    // Synchronised view

    // Two stages before any logic looks at a pin
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            s1_r <= PIN_IDLE;
            s2_r <= PIN_IDLE;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
        end
    end
    assign pin = s2_r;

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    logic acc;                  // Address phase accepted
    logic wr_r, wr_nxt;         // Write data phase pending
    logic [7:0] wa_r, wa_nxt;   // Write address
    logic [31:0] rd_r, rd_nxt;  // Read data
    logic [31:0] stat;          // Status word
    logic por_r, por_nxt;       // power_on_flag
    logic mode_wr_r, mode_wr_nxt;   // Mode request pulse
    logic [1:0] mode_r, mode_nxt;   // Requested mode

    // Zero wait states: read data is prepared in the address phase
    always_comb begin
        acc = hsel & htrans[1] & hready;
        wr_nxt = acc & hwrite;
        wa_nxt = acc ? haddr[7:0] : wa_r;
        stat = '0;
        stat[srs_pkg::STAT_POR] = por_r;
        stat[srs_pkg::STAT_SELF] = self_clock;
        stat[srs_pkg::STAT_WARN] = supply_low_warning;
        stat[srs_pkg::STAT_FULL] = full_perf;
        stat[srs_pkg::STAT_OSC] = osc_enable;
        rd_nxt = '0;
        // Unmapped and control reads return zero
        if (acc && !hwrite && haddr[7:0] == srs_pkg::ADDR_STAT) begin
            rd_nxt = stat;
        end
        por_nxt = por_r;
        mode_wr_nxt = 1'b0;
        mode_nxt = mode_r;
        if (wr_r && wa_r == srs_pkg::ADDR_CTRL) begin
            mode_wr_nxt = 1'b1;
            mode_nxt = hwdata[srs_pkg::CTRL_MODE_LSB +: 2];
        end
        // Only power-on sets the flag, so no set can be lost here
        if (wr_r && wa_r == srs_pkg::ADDR_STAT) begin
            por_nxt = por_r & ~hwdata[srs_pkg::STAT_POR];
        end
    end

    // Bus registers; power-on reset sets the flag
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_r <= 1'b0;
            wa_r <= '0;
            rd_r <= '0;
            por_r <= 1'b1;
            mode_wr_r <= 1'b0;
            mode_r <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_r <= wr_nxt;
            wa_r <= wa_nxt;
            rd_r <= rd_nxt;
            por_r <= por_nxt;
            mode_wr_r <= mode_wr_nxt;
            mode_r <= mode_nxt;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
    assign hrdata = rd_r;

    // ****************************************
    // Sequencer
    // ****************************************
    srs_pkg::srs_state_e st_r, st_nxt;
    logic [srs_pkg::CNT_W-1:0] cnt_r, cnt_nxt;  // Phase counter
    logic [12:0] good_r, good_nxt;              // Stable osc count
    logic [1:0] rstl_r, rstl_nxt;               // Reset pin low count
    logic was_r, was_nxt;       // Oscillator ran before reset
    logic wake_r, wake_nxt;     // Check entered from stop
    logic self_nxt, rel_nxt, osc_nxt, irst_nxt;
    logic rvec_nxt, ivec_nxt, full_nxt, warn_nxt, cuv_nxt;
    logic ext_rst, core_rst;

    // Next state and registered outputs
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r + 1'b1;
        good_nxt = pin.osc_ok ? good_r + 1'b1 : '0;
        was_nxt = was_r;
        wake_nxt = wake_r;
        self_nxt = self_clock;
        rvec_nxt = 1'b0;
        ivec_nxt = 1'b0;
        // Low pin is qualified after the minimum width
        rstl_nxt = pin.ext_rst_n ? 2'h0 : rstl_r + 2'(rstl_r !=
            2'(srs_pkg::RST_PULSE_MIN));
        ext_rst = rstl_r == 2'(srs_pkg::RST_PULSE_MIN);
        core_rst = full_perf & pin.core_uv;
        if (ext_rst || core_rst) begin
            // Keep the oscillator if it was on without self clock, even mid-check
            st_nxt = srs_pkg::ST_RST;
            cnt_nxt = '0;
            was_nxt = osc_enable & ~self_clock;
        end else begin
            unique case (st_r)
                srs_pkg::ST_RST: begin
                    // Startup count after the source released
                    if (cnt_r == srs_pkg::CNT_W'(srs_pkg::STARTUP_OSC
                            - 1)) begin
                        cnt_nxt = '0;
                        good_nxt = '0;
                        wake_nxt = 1'b0;
                        if (was_r) begin
                            st_nxt = srs_pkg::ST_RUN;
                            rvec_nxt = 1'b1;
                        end else begin
                            st_nxt = srs_pkg::ST_QC;
                        end
                    end
                end
                srs_pkg::ST_QC: begin
                    if (good_r == 13'(srs_pkg::QC_GOOD_CYC - 1)) begin
                        st_nxt = srs_pkg::ST_RUN;
                        self_nxt = 1'b0;
                        rvec_nxt = ~wake_r;
                        ivec_nxt = wake_r;
                    end else if (cnt_r ==
                            srs_pkg::CNT_W'(TO_CYC - 1)) begin
                        st_nxt = srs_pkg::ST_RUN;
                        self_nxt = 1'b1;
                        rvec_nxt = ~wake_r;
                        ivec_nxt = wake_r;
                    end
                end
                srs_pkg::ST_RUN: begin
                    // Software requests a low power mode
                    if (mode_wr_r) begin
                        case (mode_r)
                            srs_pkg::MODE_STOP: st_nxt = srs_pkg::ST_STOP;
                            srs_pkg::MODE_PSTOP: st_nxt = srs_pkg::ST_PSTOP;
                            srs_pkg::MODE_WAIT: st_nxt = srs_pkg::ST_WAIT;
                            default: st_nxt = srs_pkg::ST_RUN;
                        endcase
                    end
                end
                srs_pkg::ST_STOP: begin
                    // Oscillator halted: only the pin can wake
                    if (pin.ext_irq) begin
                        st_nxt = srs_pkg::ST_QC;
                        cnt_nxt = '0;
                        good_nxt = '0;
                        wake_nxt = 1'b1;
                    end
                end
                srs_pkg::ST_PSTOP, srs_pkg::ST_WAIT: begin
                    if (pin.ext_irq || int_irq) begin
                        st_nxt = srs_pkg::ST_WAKE;
                        cnt_nxt = '0;
                    end
                end
                srs_pkg::ST_WAKE: begin
                    if (cnt_r == srs_pkg::CNT_W'(srs_pkg::WAKE_DLY_CYC
                            - 1)) begin
                        st_nxt = srs_pkg::ST_RUN;
                        ivec_nxt = 1'b1;
                    end
                end
            endcase
        end
        // Oscillator off only in stop, and in reset unless it was on without self clock before
        osc_nxt = (st_nxt == srs_pkg::ST_RST) ? was_nxt :
            st_nxt != srs_pkg::ST_STOP;
        irst_nxt = st_nxt == srs_pkg::ST_RST;
        rel_nxt = st_nxt == srs_pkg::ST_RUN;
        full_nxt = st_nxt != srs_pkg::ST_STOP &&
            st_nxt != srs_pkg::ST_PSTOP;
        warn_nxt = full_nxt & pin.supply_low;
        cuv_nxt = core_rst;
    end

    // Sequencer registers; power-on lands in reset with no oscillator
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_r <= srs_pkg::ST_RST;
            cnt_r <= '0;
            good_r <= '0;
            rstl_r <= '0;
            was_r <= 1'b0;
            wake_r <= 1'b0;
            int_rst <= 1'b1;
            clk_release <= 1'b0;
            osc_enable <= 1'b0;
            self_clock <= 1'b0;
            rst_vec_fetch <= 1'b0;
            irq_vec_fetch <= 1'b0;
            full_perf <= 1'b1;
            supply_low_warning <= 1'b0;
            core_undervoltage_reset <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            good_r <= good_nxt;
            rstl_r <= rstl_nxt;
            was_r <= was_nxt;
            wake_r <= wake_nxt;
            int_rst <= irst_nxt;
            clk_release <= rel_nxt;
            osc_enable <= osc_nxt;
            self_clock <= self_nxt;
            rst_vec_fetch <= rvec_nxt;
            irq_vec_fetch <= ivec_nxt;
            full_perf <= full_nxt;
            supply_low_warning <= warn_nxt;
            core_undervoltage_reset <= cuv_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    AST_CHECK_BEFORE_CLOCKS: assert property (
        $fell(int_rst) && !clk_release |-> osc_enable && !self_clock)
        else $error("check not started with oscillator on");
    AST_TIMEOUT_FALLBACK: assert property (
        st_r == srs_pkg::ST_QC && !ext_rst && !core_rst &&
        cnt_r == srs_pkg::CNT_W'(TO_CYC - 1) &&
        good_r != 13'(srs_pkg::QC_GOOD_CYC - 1)
        |=> self_clock && clk_release)
        else $error("no self clock fallback");
    AST_PIN_RESET: assert property (
        !pin.ext_rst_n [*2] |-> ##2 int_rst)
        else $error("reset pin not qualified");
    AST_SKIP_CHECK: assert property (
        st_r == srs_pkg::ST_RST && was_r && !ext_rst && !core_rst &&
        cnt_r == srs_pkg::CNT_W'(srs_pkg::STARTUP_OSC - 1)
        |=> rst_vec_fetch && clk_release)
        else $error("quality check not skipped");
    AST_STOP_WAKE: assert property (
        st_r == srs_pkg::ST_STOP && pin.ext_irq && !ext_rst
        |=> st_r == srs_pkg::ST_QC && !clk_release && wake_r)
        else $error("stop wake without quality check");
    AST_OSC_KEPT: assert property (
        st_r == srs_pkg::ST_PSTOP || st_r == srs_pkg::ST_WAIT
        |-> osc_enable)
        else $error("oscillator stopped in light sleep");
    AST_WAKE_FETCH: assert property (
        (st_r == srs_pkg::ST_PSTOP || st_r == srs_pkg::ST_WAIT) &&
        (pin.ext_irq || int_irq) && !ext_rst && !core_rst
        |-> ##[1:14] irq_vec_fetch)
        else $error("vector fetch too late");
    AST_WARN_GATED: assert property (
        supply_low_warning |-> full_perf && $past(pin.supply_low))
        else $error("warning outside full performance");
    AST_LVR_RPM: assert property (
        st_r == srs_pkg::ST_STOP && pin.ext_rst_n && rstl_r == 2'h0
        |=> !int_rst)
        else $error("core reset in reduced power");
    AST_POR_STICKY: assert property (
        !por_r |=> !por_r)
        else $error("power_on_flag set without power-on");
    AST_STARTUP_HOLD: assert property (
        $fell(int_rst) |-> $past(cnt_r) ==
        srs_pkg::CNT_W'(srs_pkg::STARTUP_OSC - 1))
        else $error("reset released early");

    COV_FALLBACK: cover property ($rose(self_clock));
    COV_STOP_WAKE: cover property (wake_r && $rose(irq_vec_fetch));
    COV_WAIT_WAKE: cover property (st_r == srs_pkg::ST_WAKE
        ##1 irq_vec_fetch);
    COV_WARM_RESET: cover property ($rose(rst_vec_fetch) && was_r);

endmodule

// ==== tb/srs_partner.sv ====
// ****************************************
// Far side: oscillator, reset pin, irq pin
// ****************************************
module srs_partner #(
    parameter int OSC_UP = 40  // Crystal start-up cycles
) (
    input wire logic ref_clk,        // Clock
    input wire logic osc_enable,     // Oscillator enable from the block
    input wire logic osc_dead,       // Crystal never starts
    input wire logic rst_req,        // Reset pin request
    input wire logic irq_req,        // Interrupt pin request
    input wire logic low_in,         // Analog supply sagging
    input wire logic uv_in,          // Core supply sagging
    output srs_pkg::srs_pins_s pins  // Pins toward the block
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] up_r = 16'h0;  // Start-up counter
    logic [15:0] up_nxt;        // Next start-up count
    logic hold_r = 1'b0;        // Stretches the reset pulse
    logic hold_nxt;             // Next stretch state

    // Oscillation only appears some time after enable, never when dead
    always_comb begin
        up_nxt = 16'h0;
        if (osc_enable && !osc_dead) begin
            up_nxt = (up_r < 16'(OSC_UP)) ? up_r + 16'h1 : up_r;
        end
        hold_nxt = rst_req;
    end

    // Register the model state
    always_ff @(posedge ref_clk) begin
        up_r <= up_nxt;
        hold_r <= hold_nxt;
    end

    // A request of one cycle still yields a two-cycle low pulse
    always_comb begin
        pins.ext_rst_n = !(rst_req || hold_r);
        pins.osc_ok = (up_r >= 16'(OSC_UP));
        pins.ext_irq = irq_req;
        pins.supply_low = low_in;
        pins.core_uv = uv_in;
    end
endmodule

// ==== tb/tb.sv ====
// ****************************************
// Self-checking bench
// ****************************************
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TO = 20000;  // Shortened quality check timeout
    localparam int UP = 40;     // Crystal start-up in the model
    localparam int SU = srs_pkg::STARTUP_OSC;
    localparam int GD = srs_pkg::QC_GOOD_CYC;
    logic ref_clk = 1'b0;  // Bus and oscillator clock
    logic sys_rst = 1'b1;  // Power-on reset
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic hreadyout, hresp, int_rst, clk_release, osc_enable, self_clock;
    logic rst_vec_fetch, irq_vec_fetch, full_perf, supply_low_warning;
    logic core_undervoltage_reset;
    logic int_irq = 1'b0;   // Internal interrupt source
    logic osc_dead = 1'b0;  // Model stimulus
    logic rst_req = 1'b0;
    logic irq_req = 1'b0;
    logic low_in = 1'b0;
    logic uv_in = 1'b0;
    srs_pkg::srs_pins_s pins;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;

    always #50 ref_clk = ~ref_clk;

    srs_top #(.TO_CYC(TO)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pins(pins), .int_irq(int_irq), .int_rst(int_rst),
        .clk_release(clk_release), .osc_enable(osc_enable),
        .self_clock(self_clock), .rst_vec_fetch(rst_vec_fetch),
        .irq_vec_fetch(irq_vec_fetch), .full_perf(full_perf),
        .supply_low_warning(supply_low_warning),
        .core_undervoltage_reset(core_undervoltage_reset));

    srs_partner #(.OSC_UP(UP)) far_u (.ref_clk(ref_clk),
        .osc_enable(osc_enable), .osc_dead(osc_dead), .rst_req(rst_req),
        .irq_req(irq_req), .low_in(low_in), .uv_in(uv_in), .pins(pins));

    // Verdict and end of run, also reached from the hang limit
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Count lies in a window worked out from the constants
    task automatic rng(input int v, input int lo, input int hi);
        chk(32'(v >= lo && v <= hi), 32'h1);
    endtask

    // Edges from an irq request to the fetch pulse as wait_sig counts
    // them: two sync stages for the pin, the wake delay, one to register the pulse, one to see it
    function automatic int wake_cyc(input logic ext);
        return (ext ? 2 : 0) + srs_pkg::WAKE_DLY_CYC + 2;
    endfunction

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
    endtask

    // One single AHB transfer; entered and left at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hreadyout !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
        chk(32'(hresp), 32'h0);
    endtask

    // Edges until the chosen output is seen high, bounded
    task automatic wait_sig(input int s, input int lim, output int k);
        logic v;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
            case (s)
                0: v = clk_release;
                1: v = irq_vec_fetch;
                2: v = rst_vec_fetch;
                default: v = int_rst;
            endcase
        end while (v !== 1'b1 && k < lim);
    endtask

    // Hang limit, well above the longest expected run
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 90000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        logic [1:0] md;
        logic ext;
        void'($urandom(32'h74972a79));
        tick(3);
        sys_rst <= 1'b0;
        rng(srs_pkg::QC_TIMEOUT_CYC, 4_500_000, 25_000_000);
        tick(100);
        chk(int_rst, 1'b1);
        chk(osc_enable, 1'b0);
        wait_sig(0, 6000, n);
        rng(n + 100, SU + GD, SU + GD + UP + 20);
        chk(self_clock, 1'b0);
        bus(1'b0, srs_pkg::ADDR_STAT, 32'h0, q);
        chk(q[srs_pkg::STAT_POR], 1'b1);
        bus(1'b1, srs_pkg::ADDR_STAT, 32'h1, q);
        bus(1'b0, 8'h08, 32'h0, q);
        chk(q, 32'h0);
        bus(1'b0, srs_pkg::ADDR_STAT, 32'h0, q);
        chk(q[srs_pkg::STAT_POR], 1'b0);
        // External reset while the oscillator is good
        rst_req <= 1'b1;
        tick(1);
        rst_req <= 1'b0;
        wait_sig(3, 12, n);
        chk(int_rst, 1'b1);
        wait_sig(2, SU + 40, n);
        rng(n, SU, SU + 30);
        bus(1'b0, srs_pkg::ADDR_STAT, 32'h0, q);
        chk(q[srs_pkg::STAT_POR], 1'b0);
        // Pseudo stop and wait, woken by either source
        for (int i = 0; i < 6; i++) begin
            md = (i < 2) ? 2'(i + 2) : 2'($urandom_range(3, 2));
            bus(1'b1, srs_pkg::ADDR_CTRL, {30'h0, md}, q);
            tick(3 + $urandom_range(20));
            chk(clk_release, 1'b0);
            chk(osc_enable, 1'b1);
            ext = i[0] ~^ 1'($urandom_range(1));
            if (ext) begin
                irq_req <= 1'b1;
            end else begin
                int_irq <= 1'b1;
            end
            wait_sig(1, 20, n);
            int_irq <= 1'b0;
            irq_req <= 1'b0;
            rng(n, 1, 14);
            chk(n, wake_cyc(ext));
            tick(2);
        end
        // Mode code zero requests nothing and the clocks stay on
        bus(1'b1, srs_pkg::ADDR_CTRL, 32'h0, q);
        tick(3);
        chk(clk_release, 1'b1);
        // Stop: monitors off, internal irq ignored, check on wake
        bus(1'b1, srs_pkg::ADDR_CTRL, 32'h1, q);
        tick(5);
        chk(osc_enable, 1'b0);
        chk(full_perf, 1'b0);
        low_in <= 1'b1;
        uv_in <= 1'b1;
        int_irq <= 1'b1;
        tick(8);
        chk(supply_low_warning, 1'b0);
        chk(int_rst, 1'b0);
        chk(clk_release, 1'b0);
        uv_in <= 1'b0;
        int_irq <= 1'b0;
        irq_req <= 1'b1;
        tick(5);
        chk(osc_enable, 1'b1);
        irq_req <= 1'b0;
        wait_sig(1, 6000, n);
        rng(n, GD - 5, GD + UP + 20);
        tick(4);
        chk(supply_low_warning, 1'b1);
        low_in <= 1'b0;
        uv_in <= 1'b1;
        wait_sig(3, 10, n);
        chk(int_rst, 1'b1);
        chk(core_undervoltage_reset, 1'b1);
        uv_in <= 1'b0;
        wait_sig(0, 6000, n);
        // Power-on with a dead crystal falls back to self clock
        osc_dead <= 1'b1;
        sys_rst <= 1'b1;
        tick(3);
        sys_rst <= 1'b0;
        wait_sig(0, TO + 400, n);
        rng(n, TO, TO + SU + 30);
        chk(self_clock, 1'b1);
        bus(1'b0, srs_pkg::ADDR_STAT, 32'h0, q);
        chk(q[srs_pkg::STAT_POR], 1'b1);
        stop_test();
    end
endmodule
